/* File: core/asp_pkg.sv */
/*
  shared constants and types of the converter serial port core.
  assumes a single 100 MHz core clock; all pins are asynchronous to it.
*/
package asp_pkg;
  // core clock and conversion pacing in internal clock mode
  localparam int          CLK_MHZ        = 100;
  localparam int          INT_BIT_NS     = 500;
  localparam int          INT_BIT_CYC    = (INT_BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int          STEP_W         = 8;
  localparam logic [7:0]  INT_BIT_LAST   = 8'(INT_BIT_CYC - 1);
  // frame layout
  localparam int          RES_W          = 12;
  localparam logic [3:0]  CTRL_BITS      = 4'h8;
  localparam logic [3:0]  TRACK_AFTER    = 4'h5;
  localparam logic [3:0]  RES_LAST_IDX   = 4'hb;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  // clock-mode field of the control byte (low two bits)
  localparam logic [1:0]  PD_EXT_CLK     = 2'h3;
  // three-level shutdown pin as reported by the pad comparators
  localparam logic [1:0]  PWR_LOW        = 2'h0;
  localparam logic [1:0]  PWR_FLOAT      = 2'h1;
  localparam logic [1:0]  PWR_HIGH       = 2'h2;
  localparam logic [11:0] RES_ZERO       = 12'h000;
  // synchroniser idle: shutdown high, deselected, clock and data low
  localparam logic [4:0]  PIN_IDLE       = 5'h14;

  typedef enum logic [2:0] {
    ASP_IDLE,
    ASP_CTRL,
    ASP_EXT_STRB,
    ASP_EXT_CONV,
    ASP_INT_CONV,
    ASP_INT_READ
  } asp_state_t;
endpackage : asp_pkg

/* File: core/asp_sar_if.sv */
/*
  handshake between the port controller and the approximation engine.
  assumes both ends sit on clk_in.
*/
`timescale 1ns/1ns
interface asp_sar_if;
  import asp_pkg::*;
  logic             start;
  logic             step;
  logic [RES_W-1:0] sample;
  logic             cur_bit;
  logic [RES_W-1:0] result;
  logic             busy;
  logic             done;
  modport ctl (output start, output step, output sample,
               input cur_bit, input result, input busy, input done);
  modport eng (input start, input step, input sample,
               output cur_bit, output result, output busy, output done);
endinterface : asp_sar_if

/* File: core/asp_sar.sv */
/*
  successive-approximation engine: one bit decision per step, msb first.
  assumes the held sample is stable from start until done.
*/
`timescale 1ns/1ns
module asp_sar
  import asp_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // controller side
  asp_sar_if.eng    sar
);
  logic [RES_W-1:0] held_q;
  logic [RES_W-1:0] res_q;
  logic [3:0]       idx_q;
  logic             busy_q;
  logic             done_q;

  function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] i);
    bit_mask = RES_W'(1) << i;
  endfunction : bit_mask

  // decision for the bit under test, visible before the step is taken
  assign sar.cur_bit = busy_q && (held_q >= (res_q | bit_mask(idx_q)));
  assign sar.result  = res_q;
  assign sar.busy    = busy_q;
  assign sar.done    = done_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      held_q <= RES_ZERO;
      res_q  <= RES_ZERO;
      idx_q  <= RES_LAST_IDX;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sar.start) begin
        held_q <= sar.sample;
        res_q  <= RES_ZERO;
        idx_q  <= RES_LAST_IDX;
        busy_q <= 1'b1;
      end else if (busy_q && sar.step) begin
        if (sar.cur_bit) begin
          res_q <= res_q | bit_mask(idx_q);
        end
        if (idx_q == CNT_ZERO) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          idx_q <= idx_q - CNT_ONE;
        end
      end
    end
  end
endmodule : asp_sar

/* File: core/asp_top.sv */
/*
  serial port of an eight-channel 12-bit converter, pin side.
  assumes the pins are asynchronous and sampled by clk_in, a shift clock
  far slower than the core clock, and an analog front end that reports
  the selected input as a code and the shutdown pin as a level class.
*/
`timescale 1ns/1ns
// Contract
// - din is sampled at each rising shift-clock edge; host sets it up before.
// - dout changes only at falling shift-clock edges, one bit each.
// - chip select high: input ignored, dout floats.
// - internal clock mode: strobe low at conversion start, high when done.
// - external clock mode: strobe high one period before msb; floats when deselected.
// - external clock mode: shift clock paces conversion; host keeps 40-60% duty.
// - shutdown pin: low powers down, high internal, float external compensation.
// - first one after chip select falls starts an eight-bit control byte.
// - track in last three control clocks; hold at fall after eighth bit.
module asp_top
  import asp_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // serial pins
  input  wire logic             cs_n_in,
  input  wire logic             sclk_in,
  input  wire logic             din_in,
  output logic                  dout_out,
  output logic                  dout_oe_out,
  output logic                  conversion_strobe_out,
  output logic                  strobe_oe_out,
  // analog front end
  input  wire logic [1:0]       tri_level_powerdown_in,
  input  wire logic [RES_W-1:0] sample_value_in,
  output logic                  track_out,
  output logic                  powered_down_out,
  output logic                  ext_comp_out,
  output logic [7:0]            ctrl_byte_out
);
  asp_sar_if sar_bus ();

  asp_sar asp_sar_i (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .sar       (sar_bus.eng)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic       sclk_d3_q;
  logic       cs_s;
  logic       sclk_s;
  logic       din_s;
  logic [1:0] pwr_s;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pin_s1_q  <= PIN_IDLE;
      pin_s2_q  <= PIN_IDLE;
      sclk_d3_q <= 1'b0;
    end else begin
      pin_s1_q  <= {tri_level_powerdown_in, cs_n_in, sclk_in, din_in};
      pin_s2_q  <= pin_s1_q;
      sclk_d3_q <= pin_s2_q[1];
    end
  end

  assign pwr_s  = pin_s2_q[4:3];
  assign cs_s   = pin_s2_q[2];
  assign sclk_s = pin_s2_q[1];
  assign din_s  = pin_s2_q[0];
  assign rise   = sclk_s && !sclk_d3_q && !cs_s;
  assign fall   = !sclk_s && sclk_d3_q && !cs_s;

  ////////////////////////////////////////////////////////////////////////
  // power state from the three-level pin
  logic pwrdn_q;
  logic ext_comp_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pwrdn_q    <= 1'b1;
      ext_comp_q <= 1'b0;
    end else begin
      pwrdn_q    <= (pwr_s == PWR_LOW);
      ext_comp_q <= (pwr_s == PWR_FLOAT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer
  asp_state_t       state_q;
  logic [3:0]       cnt_q;
  logic [7:0]       ctrl_q;
  logic             ext_q;
  logic             track_q;
  logic [RES_W-1:0] shift_q;
  logic [STEP_W-1:0] tick_q;
  logic             int_step;
  logic             last_ctrl;
  logic             ext_conv;

  assign last_ctrl        = (state_q == ASP_CTRL) && fall && (cnt_q == CTRL_BITS);
  assign int_step         = (state_q == ASP_INT_CONV) && (tick_q == INT_BIT_LAST);
  assign sar_bus.start    = last_ctrl;
  assign sar_bus.sample   = sample_value_in;
  // the msb decision is taken at the fall that ends the strobe pulse
  assign ext_conv         = (state_q == ASP_EXT_STRB) || (state_q == ASP_EXT_CONV);
  assign sar_bus.step     = int_step || (ext_conv && fall);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= ASP_IDLE;
      cnt_q   <= CNT_ZERO;
      ctrl_q  <= 8'h00;
      ext_q   <= 1'b0;
    end else if (cs_s) begin
      // a deselect drops the frame; an internal conversion runs on, its result is lost
      state_q <= (state_q == ASP_INT_CONV && !sar_bus.done) ? ASP_INT_CONV : ASP_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      case (state_q)
        ASP_IDLE: begin
          if (rise && din_s && !pwrdn_q) begin
            state_q <= ASP_CTRL;
            cnt_q   <= CNT_ONE;
            ctrl_q  <= 8'h01;
          end
        end
        ASP_CTRL: begin
          if (rise && cnt_q != CTRL_BITS) begin
            ctrl_q <= {ctrl_q[6:0], din_s};
            cnt_q  <= cnt_q + CNT_ONE;
          end else if (last_ctrl) begin
            ext_q   <= (ctrl_q[1:0] == PD_EXT_CLK);
            state_q <= (ctrl_q[1:0] == PD_EXT_CLK) ? ASP_EXT_STRB : ASP_INT_CONV;
            cnt_q   <= CNT_ZERO;
          end
        end
        ASP_EXT_STRB: begin
          if (fall) begin
            state_q <= ASP_EXT_CONV;
          end
        end
        ASP_EXT_CONV: begin
          if (sar_bus.done) begin
            state_q <= ASP_IDLE;
          end
        end
        ASP_INT_CONV: begin
          if (sar_bus.done) begin
            state_q <= ASP_INT_READ;
            cnt_q   <= CNT_ZERO;
          end
        end
        ASP_INT_READ: begin
          if (fall) begin
            cnt_q   <= cnt_q + CNT_ONE;
            state_q <= (cnt_q == RES_LAST_IDX) ? ASP_IDLE : ASP_INT_READ;
          end
        end
        default: state_q <= ASP_IDLE;
      endcase
    end
  end

  // internal conversion clock: free-running divider while busy
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tick_q <= '0;
    end else if (state_q != ASP_INT_CONV || int_step) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + STEP_W'(1);
    end
  end

  // track from the fall after the fifth bit until the fall after the eighth
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      track_q <= 1'b0;
    end else if (cs_s || last_ctrl) begin
      track_q <= 1'b0;
    end else if (state_q == ASP_CTRL && fall && cnt_q == TRACK_AFTER) begin
      track_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output and strobe
  logic dout_q;
  logic dout_oe_q;
  logic strb_q;
  logic strb_oe_q;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dout_q  <= 1'b0;
      shift_q <= RES_ZERO;
    end else if (cs_s) begin
      dout_q <= 1'b0;
    end else if (state_q == ASP_INT_CONV && sar_bus.done) begin
      shift_q <= sar_bus.result;
    end else if (fall) begin
      if (ext_conv) begin
        dout_q <= sar_bus.cur_bit;
      end else if (state_q == ASP_INT_READ) begin
        dout_q  <= shift_q[RES_W-1];
        shift_q <= {shift_q[RES_W-2:0], 1'b0};
      end else begin
        dout_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      strb_q <= 1'b1;
    end else if (last_ctrl) begin
      // external mode pulse starts here; internal mode goes low here
      strb_q <= (ctrl_q[1:0] == PD_EXT_CLK);
    end else if (state_q == ASP_EXT_STRB && fall) begin
      strb_q <= 1'b0;
    end else if (state_q == ASP_INT_CONV && sar_bus.done) begin
      strb_q <= 1'b1;
    end else if (state_q == ASP_IDLE && ext_q) begin
      strb_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      dout_oe_q <= 1'b0;
      strb_oe_q <= 1'b1;
    end else begin
      dout_oe_q <= !cs_s;
      strb_oe_q <= !(ext_q && cs_s);
    end
  end

  assign dout_out              = dout_q;
  assign dout_oe_out           = dout_oe_q;
  assign conversion_strobe_out = strb_q;
  assign strobe_oe_out         = strb_oe_q;
  assign track_out             = track_q;
  assign powered_down_out      = pwrdn_q;
  assign ext_comp_out          = ext_comp_q;
  assign ctrl_byte_out         = ctrl_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_dout_float: assert property (cs_s |=> !dout_oe_q)
    else $error("dout driven while deselected");
  a_din_ignored: assert property (cs_s && state_q != ASP_INT_CONV
    |=> state_q == ASP_IDLE)
    else $error("frame kept while deselected");
  a_dout_on_fall: assert property ($changed(dout_q) && !$past(cs_s) |-> $past(fall))
    else $error("dout changed without a falling edge");
  a_start_bit: assert property (
    state_q == ASP_IDLE && rise && din_s && !pwrdn_q && !cs_s
    |=> state_q == ASP_CTRL && cnt_q == CNT_ONE)
    else $error("start bit not taken");
  a_hold_point: assert property (last_ctrl |=> !track_q && sar_bus.busy)
    else $error("no hold after the eighth bit");
  a_int_strobe: assert property (last_ctrl && ctrl_q[1:0] != PD_EXT_CLK
    |=> !strb_q throughout (state_q == ASP_INT_CONV)[*8])
    else $error("strobe not low during conversion");
  a_int_done: assert property (state_q == ASP_INT_CONV && sar_bus.done && !cs_s
    |=> strb_q && state_q == ASP_INT_READ)
    else $error("strobe not high after conversion");
  a_ext_pulse: assert property (state_q == ASP_EXT_STRB && fall && !cs_s
    |=> !strb_q && state_q == ASP_EXT_CONV)
    else $error("strobe pulse not one period");
  a_strobe_float: assert property (ext_q && cs_s |=> !strb_oe_q)
    else $error("strobe driven while deselected");
  a_tri_level_powerdown_in_low: assert property (pwr_s == PWR_LOW |=> pwrdn_q && !ext_comp_q)
    else $error("shutdown level not obeyed");
  a_msb_first: assert property (
    state_q == ASP_INT_READ && fall && cnt_q == CNT_ZERO && !cs_s
    |=> dout_q == sar_bus.result[RES_W-1])
    else $error("msb not first");

  c_ext_frame: cover property (state_q == ASP_EXT_CONV && sar_bus.done);
  c_int_frame: cover property (state_q == ASP_INT_READ && fall && cnt_q == RES_LAST_IDX);
  c_abort: cover property (state_q == ASP_CTRL && cs_s);
endmodule : asp_top

/* File: verif/asp_host.sv */
/*
  host model: drives select, shift clock and data, records what comes back.
  assumes clk_in is the 100 MHz bench clock; a shift period is 16 cycles.
*/
`timescale 1ns/1ns
module asp_host (
  // bench clock
  input  wire logic clk_in,
  // serial pins
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      din_out,
  input  wire logic dout_in,
  input  wire logic strobe_in,
  input  wire logic track_in
);
  // samples taken before rise k (after fall k-1) and before fall k
  logic dv [1:21];
  logic dh [1:21];
  logic st [1:21];
  logic tr [1:21];
  logic conv_low;
  logic conv_done;

  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one period, low half first; k of 0 records nothing
  task automatic shift(input logic d, input int k);
    din_out <= d;
    repeat (8) @(posedge clk_in);
    if (k > 0) begin
      dv[k] = dout_in;
      st[k] = strobe_in;
      tr[k] = track_in;
    end
    sclk_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    if (k > 0) begin
      dh[k] = dout_in;
    end
    sclk_out <= 1'b0;
  endtask : shift

  //////////////////////////////////////////////////////////////////////////
  // whole conversion: leading zeros, control byte, twelve result bits
  task automatic frame(input logic [7:0] ctrl, input int lead, output logic [11:0] res);
    int n;
    cs_n_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < lead; i++) begin
      shift(1'b0, 0);
    end
    for (int k = 1; k <= 21; k++) begin
      if (k == 9 && ctrl[1:0] != 2'h3) begin
        repeat (8) @(posedge clk_in);
        conv_low = strobe_in;
        n = 0;
        // no reading rise until the conversion reports done
        while (strobe_in !== 1'b1 && n < 1000) begin
          @(posedge clk_in);
          n++;
        end
        conv_done = strobe_in;
      end
      shift((k <= 8) ? ctrl[8 - k] : 1'b0, k);
      if (k >= 10) begin
        res[21 - k] = dv[k];
      end
    end
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (16) @(posedge clk_in);
  endtask : frame

  //////////////////////////////////////////////////////////////////////////
  // control byte only, then deselect while the conversion runs
  task automatic ctrl_only(input logic [7:0] ctrl);
    cs_n_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    for (int k = 1; k <= 8; k++) begin
      shift(ctrl[8 - k], 0);
    end
    repeat (8) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (16) @(posedge clk_in);
  endtask : ctrl_only
endmodule : asp_host

/* File: verif/adc_serial_port_pins_test.sv */
/*
  self-checking bench of the converter serial port.
  assumes an ideal front end: the result equals the held sample code.
*/
`timescale 1ns/1ns
module adc_serial_port_pins_test;
  import asp_pkg::*;
  logic        clk_in;
  logic        resetn_in;
  logic [1:0]  pin;
  logic [11:0] sample;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_oe;
  logic        strobe;
  logic        strobe_oe;
  logic        track;
  logic        pdn;
  logic        ext_comp;
  logic [7:0]  ctrl;
  logic        dout_pin;
  logic        strobe_pin;
  int          failures;
  int          samples_checked;

  always #5 clk_in = ~clk_in;

  // a released pin shows the inverse, so the host cannot read a stale value
  assign dout_pin   = dout_oe ? dout : !dout;
  assign strobe_pin = strobe_oe ? strobe : !strobe;

  asp_top asp_top_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .conversion_strobe_out(strobe), .strobe_oe_out(strobe_oe),
    .tri_level_powerdown_in(pin), .sample_value_in(sample), .track_out(track),
    .powered_down_out(pdn), .ext_comp_out(ext_comp), .ctrl_byte_out(ctrl)
  );

  asp_host asp_host_i (
    .clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(dout_pin), .strobe_in(strobe_pin), .track_in(track)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////
  task automatic test_power();
    logic [1:0] cls [3] = '{PWR_LOW, PWR_FLOAT, PWR_HIGH};
    foreach (cls[i]) begin
      pin <= cls[i];
      repeat (8) @(posedge clk_in);
      chk_bit(pdn, cls[i] == PWR_LOW, "power-down level");
      chk_bit(ext_comp, cls[i] == PWR_FLOAT, "compensation mode");
    end
  endtask : test_power

  task automatic test_ext(input logic [7:0] c, input int lead, input logic [11:0] smp);
    logic [11:0] res;
    sample <= smp;
    asp_host_i.frame(c, lead, res);
    chk_word({4'h0, ctrl}, {4'h0, c}, "ext control byte");
    for (int k = 1; k <= 9; k++) begin
      chk_bit(asp_host_i.tr[k], k >= 6 && k <= 8, "track window");
    end
    for (int k = 9; k <= 11; k++) begin
      chk_bit(asp_host_i.st[k], k == 9, "ext strobe pulse");
    end
    for (int k = 10; k <= 21; k++) begin
      chk_bit(asp_host_i.dh[k], asp_host_i.dv[k], "dout moved on rise");
    end
    chk_word(res, smp, "ext result");
    chk_bit(dout_oe, 1'b0, "dout floats deselected");
    chk_bit(strobe_oe, 1'b0, "ext strobe floats");
  endtask : test_ext

  task automatic test_int();
    logic [11:0] res;
    sample <= 12'h3c9;
    asp_host_i.frame(8'hf6, 0, res);
    chk_bit(asp_host_i.conv_low, 1'b0, "strobe low converting");
    chk_bit(asp_host_i.conv_done, 1'b1, "strobe high when done");
    chk_word(res, 12'h3c9, "int result");
    chk_word({4'h0, ctrl}, 12'h0f6, "int control byte");
    chk_bit(strobe_oe, 1'b1, "int strobe driven");
  endtask : test_int

  // start bits with select high must leave the last control byte alone
  task automatic test_desel();
    for (int i = 0; i < 8; i++) begin
      asp_host_i.shift(1'b1, 0);
    end
    repeat (8) @(posedge clk_in);
    chk_word({4'h0, ctrl}, 12'h0f6, "bits taken deselected");
    chk_bit(dout_oe, 1'b0, "dout floats deselected");
  endtask : test_desel

  // deselect during an internal conversion: it still ends, and the port is free again
  task automatic test_cut();
    asp_host_i.ctrl_only(8'hb5);
    chk_word({4'h0, ctrl}, 12'h0b5, "cut control byte");
    chk_bit(strobe, 1'b0, "strobe low while deselected");
    repeat (700) @(posedge clk_in);
    chk_bit(strobe, 1'b1, "strobe high after cut conversion");
    chk_bit(dout_oe, 1'b0, "dout floats after cut");
  endtask : test_cut

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in          = 1'b0;
    resetn_in       = 1'b0;
    pin             = PWR_HIGH;
    sample          = 12'h000;
    failures        = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    test_power();
    test_ext(8'hdb, 3, 12'ha5c);
    test_int();
    test_desel();
    test_cut();
    test_ext(8'h83, 0, 12'hfff);
    complete_run();
  end

  // four frames of under 1500 cycles each fit well inside this span
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    complete_run();
  end
endmodule : adc_serial_port_pins_test
